/* hw/sapm_top.sv */
// serial audio port configuration and monitor: offset, routing, rate and ratio monitor
//
// Operation
// (RQ1) sample starts a programmed number of bit clocks after frame start, in and out
// (RQ2) offset value equals the delay in bit clocks, zero means none
// (RQ3) left path: 00 mute, 01 left, 10 right; reset selects left
// (RQ4) right path: 00 mute, 01 right, 10 left; reset selects right
// (RQ5) software never writes the reserved code 11 to a path select
// (RQ6) detected rate code: 0 error, 2/4/6/9/b for 8/16/32/48/96 kHz
// (RQ7) upper two ratio bits appear in bits 5-4 of the rate monitor
// (RQ8) bit clocks per frame counted, low byte readable, up to 512
// (RQ9) bit clock valid only when ratio stable and within 32 to 512
// (RQ10) monitor fields refresh continuously; writes to them are ignored
// (RQ11) both ratio fields come from one frame's capture
`default_nettype none
`include "sapm_regs.svh"
module sapm_top #(
   parameter int SAMPLE_W = 24,
   parameter int CNT_W = 16
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_SERIAL_BIT_CLOCK,
   input wire logic I_FRAME_CLOCK,
   input wire logic I_SERIAL_DATA,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   output logic O_IRQ,
   output logic [SAMPLE_W-1:0] O_LEFT_PATH,
   output logic [SAMPLE_W-1:0] O_RIGHT_PATH,
   output logic O_SAMPLE_STROBE,
   output logic O_SERIAL_DATA_OUT
);
   import sapm_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] offset;
      sapm_src_t left_src;
      sapm_src_t right_src;
      sapm_irq_t int_status;
      sapm_irq_t int_enable;
      logic [7:0] rdata;
      logic [9:0] bit_cnt;
      logic [9:0] offs_cnt;
      logic [5:0] shift_cnt;
      logic capturing;
      logic in_frame;
      logic frame_side;
      logic [SAMPLE_W-1:0] shreg;
      logic [SAMPLE_W-1:0] left_smp;
      logic [SAMPLE_W-1:0] right_smp;
      logic [SAMPLE_W-1:0] out_left;
      logic [SAMPLE_W-1:0] out_right;
      logic strobe;
      logic [SAMPLE_W-1:0] tx_shreg;
      logic tx_bit;
      logic [5:0] tx_cnt;
      sapm_ratio_t ratio;
      sapm_ratio_t last_ratio;
      logic ratio_valid;
      logic [CNT_W-1:0] cyc_cnt;
      logic [CNT_W-1:0] frame_cycles;
      sapm_rate_t rate;
   } sapm_state_t;

   sapm_state_t st;
   sapm_state_t next_st;

   logic bck_rise;
   logic bck_fall;
   logic fr_level;
   logic fr_rise;
   logic din_level;
   logic [2:0] lvl;
   logic [2:0] rise;
   logic [2:0] fall;
   sapm_rate_t det_code;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // data and frame clock share the bit clock's two flops so their alignment survives
   sapm_sync #(
      .WIDTH(3)
   ) u_sync (
      .I_CLK_SYS(I_CLK_SYS),
      .I_RST_N(I_RST_N),
      .i_async({I_SERIAL_DATA, I_FRAME_CLOCK, I_SERIAL_BIT_CLOCK}),
      .o_level(lvl),
      .o_rise(rise),
      .o_fall(fall)
   );

   assign bck_rise = rise[0];
   assign bck_fall = fall[0];
   assign fr_level = lvl[1];
   assign fr_rise = rise[1];
   assign din_level = lvl[2];

   sapm_rate_det #(
      .CNT_W(CNT_W)
   ) u_rate (
      .i_frame_cycles(st.frame_cycles),
      .o_code(det_code)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [9:0] end_cnt;
      logic [9:0] tx_pos;
      logic [SAMPLE_W-1:0] tx_word;
      sapm_irq_t ev;
      end_cnt = '0;
      tx_pos = '0;
      tx_word = '0;
      ev = '0;
      next_st = st;
      next_st.strobe = 1'b0;
      next_st.rdata = 8'h00;

      // ----------------------------------------------------------------
      // frame and rate monitor
      // ----------------------------------------------------------------
      // frame timing measured in system cycles for the rate classifier
      next_st.cyc_cnt = (&st.cyc_cnt) ? st.cyc_cnt : st.cyc_cnt + CNT_W'(1);
      if (fr_rise) begin
         next_st.frame_cycles = st.cyc_cnt;
         next_st.cyc_cnt = '0;
      end
      // a lost frame clock leaves the last rate code in place until frames resume
      // rate code refreshed continuously; a change raises an event
      next_st.rate = det_code; // see (RQ6) see (RQ10)
      if (det_code != st.rate) begin
         ev[`SAPM_INT_RATE_CHG] = 1'b1;
      end

      // ----------------------------------------------------------------
      // serial capture
      // ----------------------------------------------------------------
      // serial side: data sampled on bit clock rise, frame edges seen there too
      if (bck_rise) begin
         // saturates so a runaway bit clock cannot wrap back into the legal ratio band
         end_cnt = (st.bit_cnt == 10'h3ff) ? st.bit_cnt : st.bit_cnt + 10'd1;
         next_st.bit_cnt = end_cnt;
         if (fr_level != st.frame_side) begin
            next_st.frame_side = fr_level;
            next_st.in_frame = 1'b1;
            next_st.offs_cnt = 10'd0;
            next_st.shift_cnt = '0;
            next_st.capturing = (st.offset == 8'h00); // see (RQ2)
            if (!fr_level) begin
               // one frame is a full frame clock period; count ends at its falling edge
               // the rise that opens a frame is the first one of the next count
               next_st.bit_cnt = 10'd1;
               next_st.ratio = st.bit_cnt; // see (RQ8) see (RQ11)
               next_st.last_ratio = st.ratio;
               // valid needs two equal frames in a row, so it lags a ratio change by a frame
               next_st.ratio_valid = (st.bit_cnt == st.ratio) && (st.bit_cnt >= `SAPM_RATIO_MIN)
                  && (st.bit_cnt <= `SAPM_RATIO_MAX); // see (RQ9)
               if (next_st.ratio_valid != st.ratio_valid) begin
                  ev[`SAPM_INT_VALID_CHG] = 1'b1;
               end
               if ((st.bit_cnt < `SAPM_RATIO_MIN) || (st.bit_cnt > `SAPM_RATIO_MAX)) begin
                  ev[`SAPM_INT_RATIO_ERR] = 1'b1;
               end
            end
            if (st.offset == 8'h00) begin
               next_st.shreg = {st.shreg[SAMPLE_W-2:0], din_level};
               next_st.shift_cnt = 6'd1;
            end
         end else if (st.in_frame) begin
            next_st.offs_cnt = st.offs_cnt + 10'd1;
            // offset counted in bit clocks from the first bit of each half frame
            if (!st.capturing && (st.offs_cnt + 10'd1 == {2'b00, st.offset})) begin // see (RQ1)
               next_st.capturing = 1'b1;
            end
            if (next_st.capturing && (st.shift_cnt != 6'(SAMPLE_W))) begin
               next_st.shreg = {st.shreg[SAMPLE_W-2:0], din_level};
               next_st.shift_cnt = st.shift_cnt + 6'd1;
               if (st.shift_cnt + 6'd1 == 6'(SAMPLE_W)) begin
                  if (st.frame_side) begin
                     next_st.left_smp = {st.shreg[SAMPLE_W-2:0], din_level};
                  end else begin
                     next_st.right_smp = {st.shreg[SAMPLE_W-2:0], din_level};
                     next_st.strobe = 1'b1;
                  end
               end
            end
         end
      end

      // ----------------------------------------------------------------
      // channel routing
      // ----------------------------------------------------------------
      // routing applied once both halves of a frame are in
      if (next_st.strobe) begin
         // reserved code 11 falls to mute so a stray write stays silent
         case (st.left_src) // see (RQ3)
            `SAPM_SRC_SAME: next_st.out_left = st.left_smp;
            `SAPM_SRC_SWAP: next_st.out_left = next_st.right_smp;
            default: next_st.out_left = '0;
         endcase
         case (st.right_src) // see (RQ4)
            `SAPM_SRC_SAME: next_st.out_right = next_st.right_smp;
            `SAPM_SRC_SWAP: next_st.out_right = st.left_smp;
            default: next_st.out_right = '0;
         endcase
      end

      // ----------------------------------------------------------------
      // serial output
      // ----------------------------------------------------------------
      // output data launched on bit clock fall with the same offset as the input
      // each half carries the pair routed in the previous frame: one frame of latency
      if (bck_fall) begin
         next_st.tx_bit = 1'b0;
         if (fr_level != st.frame_side) begin
            // this fall opens a half: it is slot zero and the routed word is loaded
            tx_word = fr_level ? st.out_left : st.out_right;
            tx_pos = 10'd0;
            next_st.tx_cnt = 6'd0;
         end else begin
            tx_word = st.tx_shreg;
            tx_pos = st.offs_cnt + 10'd1;
         end
         next_st.tx_shreg = tx_word;
         if ((tx_pos >= {2'b00, st.offset}) && (next_st.tx_cnt != 6'(SAMPLE_W))) begin // see (RQ1)
            next_st.tx_bit = tx_word[SAMPLE_W-1];
            next_st.tx_shreg = {tx_word[SAMPLE_W-2:0], 1'b0};
            next_st.tx_cnt = next_st.tx_cnt + 6'd1;
         end
      end

      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      // register writes; monitor addresses take no write
      if (I_WR) begin
         case (I_ADDR)
            `SAPM_ADDR_OFFSET: next_st.offset = I_WDATA;
            `SAPM_ADDR_ROUTE: begin
               next_st.left_src = I_WDATA[`SAPM_LEFT_SRC_HI:`SAPM_LEFT_SRC_LO];
               next_st.right_src = I_WDATA[`SAPM_RIGHT_SRC_HI:`SAPM_RIGHT_SRC_LO];
            end
            `SAPM_ADDR_INT_ENABLE: next_st.int_enable = I_WDATA[2:0];
            `SAPM_ADDR_INT_CLEAR: next_st.int_status = st.int_status & ~I_WDATA[2:0];
            default: next_st.int_status = st.int_status; // see (RQ10)
         endcase
      end
      // an event in the clearing cycle survives the clear
      next_st.int_status = next_st.int_status | ev;

      // ----------------------------------------------------------------
      // register reads
      // ----------------------------------------------------------------
      // reserved route bits read as zero: only the two selects are stored
      if (I_RD) begin
         case (I_ADDR)
            `SAPM_ADDR_OFFSET: next_st.rdata = st.offset;
            `SAPM_ADDR_ROUTE: next_st.rdata = {2'b00, st.left_src, 2'b00, st.right_src};
            `SAPM_ADDR_RATE: next_st.rdata = {2'b00, st.ratio[9:8], st.rate}; // see (RQ7)
            `SAPM_ADDR_RATIO_LOW: next_st.rdata = st.ratio[7:0]; // see (RQ8) see (RQ11)
            `SAPM_ADDR_INT_STATUS: next_st.rdata = {5'h00, st.int_status};
            `SAPM_ADDR_INT_ENABLE: next_st.rdata = {5'h00, st.int_enable};
            `SAPM_ADDR_LINK_STATUS: next_st.rdata = {7'h00, st.ratio_valid}; // see (RQ9)
            default: next_st.rdata = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st <= '0;
         st.offset <= `SAPM_RST_OFFSET;
         // both path selects start straight through
         st.left_src <= `SAPM_SRC_SAME; // see (RQ3)
         st.right_src <= `SAPM_SRC_SAME; // see (RQ4)
         st.int_enable <= `SAPM_RST_INT_ENABLE;
         st.rate <= `SAPM_RATE_ERR;
      end else begin
         st <= next_st;
      end
   end

   assign O_RDATA = st.rdata;
   assign O_IRQ = |(st.int_status & st.int_enable);
   assign O_LEFT_PATH = st.out_left;
   assign O_RIGHT_PATH = st.out_right;
   assign O_SAMPLE_STROBE = st.strobe;
   assign O_SERIAL_DATA_OUT = st.tx_bit;
endmodule
`default_nettype wire

/* hw/sapm_regs.svh */
// register offsets, field positions, reset values and timing constants of the audio port monitor
`ifndef SAPM_REGS_SVH
`define SAPM_REGS_SVH

`define SAPM_ADDR_OFFSET      8'h34
`define SAPM_ADDR_ROUTE       8'h35
`define SAPM_ADDR_RATE        8'h37
`define SAPM_ADDR_RATIO_LOW   8'h38
`define SAPM_ADDR_INT_STATUS  8'h3a
`define SAPM_ADDR_INT_ENABLE  8'h3b
`define SAPM_ADDR_INT_CLEAR   8'h3c
`define SAPM_ADDR_LINK_STATUS 8'h3d

`define SAPM_RST_OFFSET       8'h00
`define SAPM_RST_ROUTE        8'h11
`define SAPM_RST_INT_ENABLE   3'h0

`define SAPM_LEFT_SRC_HI      5
`define SAPM_LEFT_SRC_LO      4
`define SAPM_RIGHT_SRC_HI     1
`define SAPM_RIGHT_SRC_LO     0
`define SAPM_RATIO_HI_MSB     5
`define SAPM_RATIO_HI_LSB     4

`define SAPM_SRC_MUTE         2'h0
`define SAPM_SRC_SAME         2'h1
`define SAPM_SRC_SWAP         2'h2

`define SAPM_RATE_ERR         4'h0
`define SAPM_RATE_8K          4'h2
`define SAPM_RATE_16K         4'h4
`define SAPM_RATE_32K         4'h6
`define SAPM_RATE_48K         4'h9
`define SAPM_RATE_96K         4'hb

`define SAPM_RATIO_MIN        10'd32
`define SAPM_RATIO_MAX        10'd512

`define SAPM_CLK_HZ           125000000
`define SAPM_RATE_TOL_PCT     2

`define SAPM_INT_RATE_CHG     0
`define SAPM_INT_VALID_CHG    1
`define SAPM_INT_RATIO_ERR    2

`endif

/* hw/sapm_pkg.sv */
// types shared by the audio port monitor
`default_nettype none
package sapm_pkg;
   typedef logic [1:0] sapm_src_t;
   typedef logic [3:0] sapm_rate_t;
   typedef logic [9:0] sapm_ratio_t;
   typedef logic [2:0] sapm_irq_t;
endpackage
`default_nettype wire

/* hw/sapm_sync.sv */
// two-flop synchroniser with edge detection for the serial clocks and data
`default_nettype none
module sapm_sync #(
   parameter int WIDTH = 3
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
      logic [WIDTH-1:0] prev;
   } sapm_sync_state_t;

   sapm_sync_state_t st;
   sapm_sync_state_t next_st;

   always_comb begin
      next_st = st;
      next_st.meta = i_async;
      next_st.sync = st.meta;
      next_st.prev = st.sync;
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_level = st.sync;
   assign o_rise = st.sync & ~st.prev;
   assign o_fall = ~st.sync & st.prev;
endmodule
`default_nettype wire

/* hw/sapm_rate_det.sv */
// sample-rate classifier: frame length in system cycles to rate code
`default_nettype none
`include "sapm_regs.svh"
module sapm_rate_det #(
   parameter int CNT_W = 16
) (
   input wire logic [CNT_W-1:0] i_frame_cycles,
   output sapm_pkg::sapm_rate_t o_code
);
   import sapm_pkg::*;

   // nominal frame length in system cycles for a given rate
   function automatic logic [CNT_W-1:0] nom(input int hz);
      return CNT_W'(`SAPM_CLK_HZ / hz);
   endfunction

   function automatic logic near(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] n);
      logic [CNT_W+7:0] tol;
      tol = (CNT_W+8)'(n) * (CNT_W+8)'(`SAPM_RATE_TOL_PCT) / (CNT_W+8)'(100);
      return ((CNT_W+8)'(v) + tol >= (CNT_W+8)'(n)) && ((CNT_W+8)'(v) <= (CNT_W+8)'(n) + tol);
   endfunction

   always_comb begin
      // tolerance window absorbs the half-period sampling jitter of the frame clock
      if (near(i_frame_cycles, nom(8000))) begin
         o_code = `SAPM_RATE_8K;
      end else if (near(i_frame_cycles, nom(16000))) begin
         o_code = `SAPM_RATE_16K;
      end else if (near(i_frame_cycles, nom(32000))) begin
         o_code = `SAPM_RATE_32K;
      end else if (near(i_frame_cycles, nom(48000))) begin
         o_code = `SAPM_RATE_48K;
      end else if (near(i_frame_cycles, nom(96000))) begin
         o_code = `SAPM_RATE_96K;
      end else begin
         o_code = `SAPM_RATE_ERR;
      end
   end
endmodule
`default_nettype wire

/* tb/sapm_chk.sv */
// assertion checker bound to the audio port monitor top
`default_nettype none
module sapm_chk #(
   parameter int SAMPLE_W = 24,
   parameter int CNT_W = 16
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_SERIAL_BIT_CLOCK,
   input wire logic I_FRAME_CLOCK,
   input wire logic I_SERIAL_DATA,
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   input wire logic O_IRQ,
   input wire logic [SAMPLE_W-1:0] O_LEFT_PATH,
   input wire logic [SAMPLE_W-1:0] O_RIGHT_PATH,
   input wire logic O_SAMPLE_STROBE,
   input wire logic O_SERIAL_DATA_OUT
);
   // shadows of the writable registers; route age proves a whole frame saw one route
   logic [7:0] off_sh;
   logic [7:0] rt_sh;
   logic [2:0] en_sh;
   logic [13:0] rt_age;
   logic rt_wr;
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_N);
   assign rt_wr = I_WR && I_ADDR == 8'h35;
   always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
      if (!I_RST_N) begin
         off_sh <= 8'h00;
         rt_sh <= 8'h11;
         en_sh <= 3'h0;
         rt_age <= 14'h0000;
      end else begin
         off_sh <= (I_WR && I_ADDR == 8'h34) ? I_WDATA : off_sh;
         rt_sh <= rt_wr ? I_WDATA : rt_sh;
         en_sh <= (I_WR && I_ADDR == 8'h3b) ? I_WDATA[2:0] : en_sh;
         rt_age <= rt_wr ? 14'h0000 : rt_age + {13'h0000, rt_age != 14'h3fff};
      end
   end
   // ----
   // properties
   // ----
   offset_read_a: assert property (I_RD && I_ADDR == 8'h34 |=> O_RDATA == $past(off_sh))
      else $error("offset readback wrong");
   route_read_a: assert property (I_RD && I_ADDR == 8'h35 |=> O_RDATA == $past(rt_sh))
      else $error("route readback wrong");
   rate_code_a: assert property (I_RD && I_ADDR == 8'h37 |=>
      O_RDATA[3:0] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h9, 4'hb}) else $error("illegal rate code");
   rate_rsvd_a: assert property (I_RD && I_ADDR == 8'h37 |=> O_RDATA[7:6] == 2'h0)
      else $error("rate monitor top bits set");
   left_mute_a: assert property (O_SAMPLE_STROBE && rt_age > 14'h1004 && rt_sh[5:4] == 2'h0
      |-> O_LEFT_PATH == '0) else $error("left path not muted");
   right_mute_a: assert property (O_SAMPLE_STROBE && rt_age > 14'h1004 && rt_sh[1:0] == 2'h0
      |-> O_RIGHT_PATH == '0) else $error("right path not muted");
   path_hold_a: assert property (!O_SAMPLE_STROBE |->
      $stable(O_LEFT_PATH) && $stable(O_RIGHT_PATH)) else $error("path moved without strobe");
   strobe_pulse_a: assert property (O_SAMPLE_STROBE |=> !O_SAMPLE_STROBE)
      else $error("strobe longer than one cycle");
   irq_mask_a: assert property (en_sh == 3'h0 && $past(en_sh) == 3'h0 |-> !O_IRQ)
      else $error("interrupt while all disabled");
   idle_rdata_a: assert property (!I_RD |=> O_RDATA == 8'h00)
      else $error("read data outside read cycle");
endmodule
bind sapm_top sapm_chk #(.SAMPLE_W(SAMPLE_W), .CNT_W(CNT_W)) u_chk (.I_CLK_SYS, .I_RST_N,
   .I_SERIAL_BIT_CLOCK, .I_FRAME_CLOCK, .I_SERIAL_DATA, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
   .O_RDATA, .O_IRQ, .O_LEFT_PATH, .O_RIGHT_PATH, .O_SAMPLE_STROBE, .O_SERIAL_DATA_OUT);
`default_nettype wire

/* tb/sapm_host.sv */
// host audio source model: bit clock, frame clock and serial data
`default_nettype none
module sapm_host #(
   parameter int SAMPLE_W = 24
) (
   input wire logic i_run,
   input wire logic [9:0] i_ratio,
   input wire logic [7:0] i_offset,
   input wire logic [SAMPLE_W-1:0] i_left,
   input wire logic [SAMPLE_W-1:0] i_right,
   input wire logic i_sdo,
   output logic o_bck,
   output logic o_lrck,
   output logic o_data,
   output logic [SAMPLE_W-1:0] o_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos;
   logic [SAMPLE_W-1:0] word;
   logic [SAMPLE_W-1:0] rx;
   initial begin
      rx = '0;
      o_rx = '0;
      o_bck = 1'b0;
      o_lrck = 1'b0;
      o_data = 1'b0;
      #3;
      forever begin
         if (!i_run) begin
            // clock stands still while i_run is low; the released data line wanders
            #64 o_data = ~o_data;
         end else begin
            for (int h = 0; h < 2; h++) begin
               word = (h == 0) ? i_left : i_right;
               for (int j = 0; j < int'(i_ratio) / 2; j++) begin
                  pos = j - int'(i_offset);
                  o_bck = 1'b0;
                  o_lrck = (h == 0);
                  o_data = (pos >= 0 && pos < SAMPLE_W) ? word[SAMPLE_W-1-pos] : j[0];
                  #32 o_bck = 1'b1;
                  // the block's output is taken at the rising edge, in the same slots
                  if (pos >= 0 && pos < SAMPLE_W) begin
                     rx[SAMPLE_W-1-pos] = i_sdo;
                  end
                  #32;
               end
               if (h == 0) begin
                  o_rx = rx;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* tb/sapm_top_tb.sv */
// self-checking bench for the audio port monitor
`default_nettype none
module sapm_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sapm_pkg::*;
   localparam int SW = 24;
   localparam logic [7:0] rt_tab [4] = '{8'h01, 8'h12, 8'h20, 8'h11};
   localparam logic [7:0] of_tab [4] = '{8'h00, 8'h01, 8'h02, 8'hc8};
   localparam logic [9:0] ra_tab [4] = '{10'h1e8, 10'h040, 10'h200, 10'h010};
   localparam logic [7:0] e37_tab [4] = '{8'h16, 8'h00, 8'h20, 8'h00};
   localparam logic [7:0] e38_tab [4] = '{8'he8, 8'h40, 8'h00, 8'h10};
   localparam logic [7:0] e3d_tab [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
   logic clk;
   logic rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic rd_d = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic [SW-1:0] lp;
   logic [SW-1:0] rp;
   logic stb;
   logic serial_bit_clock;
   logic lrck;
   logic sdat;
   logic run;
   logic [9:0] ratio;
   logic [7:0] offs;
   logic [SW-1:0] lsm;
   logic [SW-1:0] rsm;
   logic sout;
   logic [SW-1:0] rxl;
   logic [SW-1:0] exl;
   logic [31:0] seed = 32'h00000035;
   logic [7:0] rq[$];
   logic [2*SW-1:0] pq[$];
   int mismatches = 0;
   int num_checks = 0;
   sapm_top #(.SAMPLE_W(SW), .CNT_W(16)) dut (.I_CLK_SYS(clk), .I_RST_N(rst_n),
      .I_SERIAL_BIT_CLOCK(serial_bit_clock), .I_FRAME_CLOCK(lrck), .I_SERIAL_DATA(sdat), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .O_LEFT_PATH(lp),
      .O_RIGHT_PATH(rp), .O_SAMPLE_STROBE(stb), .O_SERIAL_DATA_OUT(sout));
   sapm_host #(.SAMPLE_W(SW)) host (.i_run(run), .i_ratio(ratio), .i_offset(offs),
      .i_left(lsm), .i_right(rsm), .i_sdo(sout), .o_bck(serial_bit_clock), .o_lrck(lrck), .o_data(sdat),
      .o_rx(rxl));
   // ----
   // helpers
   // ----
   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic logic [SW-1:0] sel(input logic [1:0] c, input logic [SW-1:0] s,
                                         input logic [SW-1:0] o);
      return (c == 2'h1) ? s : ((c == 2'h2) ? o : '0);
   endfunction
   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // waits for frame clock falls, bounded so a dead link ends the run
   task automatic frames(input int n);
      int k;
      repeat (n) begin
         k = 0;
         while (lrck !== 1'b1 && k < 9000) begin
            @(posedge clk);
            k++;
         end
         while (lrck !== 1'b0 && k < 9000) begin
            @(posedge clk);
            k++;
         end
         if (k >= 9000) begin
            mismatches++;
            $display("Error at %0t: frame clock stalled", $time);
            test_done();
         end
      end
   endtask
   always @(posedge clk) begin
      rd_d <= rd;
      if (rd_d && rq.size() > 0) check(rdata, rq.pop_front());
      if (stb && pq.size() > 0) check({lp, rp}, pq.pop_front());
   end
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----
   // main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      run = 1'b0;
      ratio = 10'h1e8;
      offs = 8'h00;
      lsm = '0;
      rsm = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rreg(8'h34, 8'h00);
      rreg(8'h35, 8'h11);
      rreg(8'h37, 8'h00);
      rreg(8'h38, 8'h00);
      rreg(8'h36, 8'h00);
      seed = xs(seed);
      wreg(8'h34, seed[7:0]);
      rreg(8'h34, seed[7:0]);
      wreg(8'h37, 8'hff);
      rreg(8'h37, 8'h00);
      wreg(8'h38, 8'h5a);
      rreg(8'h38, 8'h00);
      run <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         lsm <= seed[SW-1:0];
         seed = xs(seed);
         rsm <= seed[SW-1:0];
         offs <= of_tab[i];
         wreg(8'h34, of_tab[i]);
         wreg(8'h35, rt_tab[i]);
         frames(2);
         exl = sel(rt_tab[i][5:4], lsm, rsm);
         pq.push_back({exl, sel(rt_tab[i][1:0], rsm, lsm)});
         frames(1);
         check(rxl, exl);
      end
      for (int i = 0; i < 4; i++) begin
         ratio <= ra_tab[i];
         frames(3);
         rreg(8'h37, e37_tab[i]);
         rreg(8'h38, e38_tab[i]);
         rreg(8'h3d, e3d_tab[i]);
      end
      wreg(8'h3b, 8'h04);
      repeat (3) @(posedge clk);
      check(irq, 1'b1);
      wreg(8'h3b, 8'h00);
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
      run <= 1'b0;
      repeat (400) @(posedge clk);
      wreg(8'h3b, 8'h07);
      repeat (3) @(posedge clk);
      check(irq, 1'b1);
      wreg(8'h3c, 8'h07);
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
      rreg(8'h3a, 8'h00);
      repeat (3) @(posedge clk);
      test_done();
   end
endmodule
`default_nettype wire
